// ---- inc/flash_seq_defines.vh ----
// opcodes, status layout, operation kinds and timing of the flash
// sequencer; included by the sequencer and needs nothing else
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

`define ADDR_BITS           24
`define ENTRY_BITS          43

`define OPC_BYTE_PROG       8'h02
`define OPC_INC_WORD        8'had
`define OPC_SECT_ERASE      8'h20
`define OPC_BLK32_ERASE     8'h52
`define OPC_BLK64_ERASE     8'hd8
`define OPC_CHIP_ERASE_A    8'h60
`define OPC_CHIP_ERASE_B    8'hc7
`define OPC_STATUS_READ     8'h05
`define OPC_WRITE_ENABLE    8'h06
`define OPC_WRITE_DISABLE   8'h04
`define OPC_HW_BUSY_ON      8'h70
`define OPC_HW_BUSY_OFF     8'h80

`define STAT_BUSY_BIT       0
`define STAT_WEN_BIT        1
`define STAT_INC_BIT        6

`define KIND_NONE           3'h0
`define KIND_BYTE_PROG      3'h1
`define KIND_WORD_PROG      3'h2
`define KIND_SECT_ERASE     3'h3
`define KIND_BLK32_ERASE    3'h4
`define KIND_BLK64_ERASE    3'h5
`define KIND_CHIP_ERASE     3'h6

`define LEN_OPCODE_ONLY     3'h1
`define LEN_INC_NEXT        3'h3
`define LEN_ERASE           3'h4
`define LEN_BYTE_PROG       3'h5
`define LEN_INC_FIRST       3'h6

`define MASK_BYTE           24'h000000
`define MASK_WORD           24'h000001
`define MASK_SECTOR         24'h000fff
`define MASK_BLK32          24'h007fff
`define MASK_BLK64          24'h00ffff
`define MASK_CHIP           24'hffffff
`define ADDR_STEP           24'h000002

`define CLK_MHZ             200
`define BYTE_PROGRAM_TIME_US 10
`define SECTOR_ERASE_TIME_US 25000
`define BLOCK_ERASE_TIME_US  25000
`define CHIP_ERASE_TIME_US   50000

`endif

// ---- design/sync_edge.v ----
// two-flop synchroniser with edge detection for a group of pins
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/1ps
module sync_edge #(
    parameter W = 3
) (
    input  wire         clk_sys,
    input  wire         arst_n,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] level,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;
reg [W-1:0] prev_q;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        meta_q <= {W{1'b1}};
        sync_q <= {W{1'b1}};
        prev_q <= {W{1'b1}};
    end else begin
        meta_q <= async_in;
        sync_q <= meta_q;
        prev_q <= sync_q;
    end
end

assign level = sync_q;
assign rise  = sync_q & ~prev_q;
assign fall  = ~sync_q & prev_q;

endmodule

// ---- design/op_skid_buffer.v ----
// two-entry buffer with valid/ready on both sides; outputs are registers
// assumes both sides run on clk_sys
`timescale 1ns/1ps
module op_skid_buffer #(
    parameter W = 43
) (
    input  wire         clk_sys,
    input  wire         arst_n,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

reg         out_v_q;
reg [W-1:0] out_q;
reg         spare_v_q;
reg [W-1:0] spare_q;
wire        push = in_valid & ~spare_v_q;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        out_v_q   <= 1'b0;
        out_q     <= {W{1'b0}};
        spare_v_q <= 1'b0;
        spare_q   <= {W{1'b0}};
    end else if (!out_v_q || out_ready) begin
        if (spare_v_q) begin
            out_q     <= spare_q;
            out_v_q   <= 1'b1;
            spare_v_q <= 1'b0;
        end else begin
            out_q   <= in_data;
            out_v_q <= push;
        end
    end else if (push) begin
        // head stalled: park the word so nothing is lost
        spare_q   <= in_data;
        spare_v_q <= 1'b1;
    end
end

assign in_ready  = ~spare_v_q;
assign out_valid = out_v_q;
assign out_data  = out_q;

endmodule

// ---- design/spi_flash_program_erase_sequencer.v ----
// program/erase command sequencer of a serial nor flash
// assumes spi pins are asynchronous; array backend takes ops on op_*
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module spi_flash_program_erase_sequencer #(
    parameter [31:0] BP_CYC = `BYTE_PROGRAM_TIME_US * `CLK_MHZ,
    parameter [31:0] SE_CYC = `SECTOR_ERASE_TIME_US * `CLK_MHZ,
    parameter [31:0] BE_CYC = `BLOCK_ERASE_TIME_US * `CLK_MHZ,
    parameter [31:0] CE_CYC = `CHIP_ERASE_TIME_US * `CLK_MHZ
) (
    input  wire                  clk_sys,
    input  wire                  arst_n,
    input  wire                  cs_n_pin,
    input  wire                  sclk_pin,
    input  wire                  si_pin,
    output wire                  so_out,
    output wire                  so_oe,
    input  wire [`ADDR_BITS-1:0] unprot_top,
    output wire                  op_valid,
    input  wire                  op_ready,
    output wire [2:0]            op_kind,
    output wire [`ADDR_BITS-1:0] op_addr,
    output wire [15:0]           op_data,
    output wire                  busy,
    output wire                  write_enable_latch,
    output wire                  auto_increment_program,
    output wire                  hw_busy_en
);

////////////////////////////////////////////////////////////////////////
// pin synchronisation

wire [2:0] pin_lvl;
wire [2:0] pin_rise;
wire [2:0] pin_fall;

sync_edge #(
    .W (3)
) u_sync (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .async_in ({cs_n_pin, sclk_pin, si_pin}),
    .level    (pin_lvl),
    .rise     (pin_rise),
    .fall     (pin_fall)
);

wire cs_low  = ~pin_lvl[2];
wire cs_end  = pin_rise[2];
wire sclk_up = pin_rise[1] & cs_low;
wire sclk_dn = pin_fall[1] & cs_low;
wire si_bit  = pin_lvl[0];

////////////////////////////////////////////////////////////////////////
// state

reg [2:0]            bit_q;
reg [2:0]            cnt_q;
reg [6:0]            sh_q;
reg [7:0]            opc_q;
reg [39:0]           pay_q;
reg                  rd_q;
reg [7:0]            osh_q;
reg                  so_q;
reg                  so_oe_q;
reg                  wen_q;
reg                  inc_q;
reg                  inc_last_q;
reg [`ADDR_BITS-1:0] ptr_q;
reg                  hwb_q;
reg                  busy_q;
reg [31:0]           tmr_q;
reg                  push_v_q;
reg [`ENTRY_BITS-1:0] push_q;
wire                 push_rdy;

wire [7:0] byte_in   = {sh_q, si_bit};
wire       byte_done = sclk_up & (bit_q == 3'h7);
wire [7:0] status    = {1'b0, inc_q, 4'h0, wen_q, busy_q};

// true when the whole span [base|mask] lies below the protected area
function span_ok;
    input [`ADDR_BITS-1:0] base;
    input [`ADDR_BITS-1:0] mask;
    input [`ADDR_BITS-1:0] top;
    begin
        span_ok = ((base | mask) <= top);
    end
endfunction

////////////////////////////////////////////////////////////////////////
// command decode at chip select rise

wire [`ADDR_BITS-1:0] adr_full = pay_q[39:16];
wire [`ADDR_BITS-1:0] adr_byte = pay_q[31:8];
wire [`ADDR_BITS-1:0] adr_ers  = pay_q[23:0];
wire                  frame_ok = cs_end & (bit_q == 3'h0);

reg                  go;
reg                  go_inc;
reg [2:0]            go_kind;
reg [`ADDR_BITS-1:0] go_adr;
reg [15:0]           go_dat;
reg [31:0]           go_cyc;

always @* begin
    go      = 1'b0;
    go_inc  = 1'b0;
    go_kind = `KIND_NONE;
    go_adr  = {`ADDR_BITS{1'b0}};
    go_dat  = 16'hffff;
    go_cyc  = 32'h0;
    if (frame_ok && wen_q && !busy_q) begin
        case (opc_q)
            `OPC_BYTE_PROG: begin
                if (!inc_q && cnt_q == `LEN_BYTE_PROG &&
                        span_ok(adr_byte, `MASK_BYTE, unprot_top)) begin
                    go      = 1'b1;
                    go_kind = `KIND_BYTE_PROG;
                    go_adr  = adr_byte;
                    go_dat  = {pay_q[7:0], 8'hff};
                    go_cyc  = BP_CYC;
                end
            end
            `OPC_INC_WORD: begin
                if (inc_q && cnt_q == `LEN_INC_NEXT) begin
                    go      = 1'b1;
                    go_kind = `KIND_WORD_PROG;
                    go_adr  = ptr_q;
                    go_dat  = pay_q[15:0];
                    go_cyc  = BP_CYC;
                end else if (!inc_q && cnt_q == `LEN_INC_FIRST &&
                        span_ok(adr_full, `MASK_WORD, unprot_top)) begin
                    go      = 1'b1;
                    go_inc  = 1'b1;
                    go_kind = `KIND_WORD_PROG;
                    go_adr  = adr_full & ~`MASK_WORD;
                    go_dat  = pay_q[15:0];
                    go_cyc  = BP_CYC;
                end
            end
            `OPC_SECT_ERASE: begin
                if (!inc_q && cnt_q == `LEN_ERASE &&
                        span_ok(adr_ers, `MASK_SECTOR, unprot_top)) begin
                    go      = 1'b1;
                    go_kind = `KIND_SECT_ERASE;
                    go_adr  = adr_ers & ~`MASK_SECTOR;
                    go_cyc  = SE_CYC;
                end
            end
            `OPC_BLK32_ERASE: begin
                if (!inc_q && cnt_q == `LEN_ERASE &&
                        span_ok(adr_ers, `MASK_BLK32, unprot_top)) begin
                    go      = 1'b1;
                    go_kind = `KIND_BLK32_ERASE;
                    go_adr  = adr_ers & ~`MASK_BLK32;
                    go_cyc  = BE_CYC;
                end
            end
            `OPC_BLK64_ERASE: begin
                if (!inc_q && cnt_q == `LEN_ERASE &&
                        span_ok(adr_ers, `MASK_BLK64, unprot_top)) begin
                    go      = 1'b1;
                    go_kind = `KIND_BLK64_ERASE;
                    go_adr  = adr_ers & ~`MASK_BLK64;
                    go_cyc  = BE_CYC;
                end
            end
            `OPC_CHIP_ERASE_A,
            `OPC_CHIP_ERASE_B: begin
                if (!inc_q && cnt_q == `LEN_OPCODE_ONLY &&
                        span_ok(`MASK_BYTE, `MASK_CHIP, unprot_top)) begin
                    go      = 1'b1;
                    go_kind = `KIND_CHIP_ERASE;
                    go_cyc  = CE_CYC;
                end
            end
            default: begin
            end
        endcase
    end
end

wire one_op = frame_ok & (cnt_q == `LEN_OPCODE_ONLY);

////////////////////////////////////////////////////////////////////////
// serial shift-in

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        bit_q <= 3'h0;
        cnt_q <= 3'h0;
        sh_q  <= 7'h00;
        opc_q <= 8'h00;
        pay_q <= 40'h0;
    end else if (pin_fall[2]) begin
        bit_q <= 3'h0;
        cnt_q <= 3'h0;
    end else if (sclk_up) begin
        bit_q <= bit_q + 3'h1;
        sh_q  <= byte_in[6:0];
        if (byte_done) begin
            if (cnt_q != 3'h7)
                cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h0)
                opc_q <= byte_in;
            else
                pay_q <= {pay_q[31:0], byte_in};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// serial output: status stream or ready/busy level

wire rd_start = byte_done & (cnt_q == 3'h0) &
                (byte_in == `OPC_STATUS_READ);
wire hw_show  = hwb_q & inc_q & cs_low & ~rd_q;

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        rd_q    <= 1'b0;
        osh_q   <= 8'h00;
        so_q    <= 1'b0;
        so_oe_q <= 1'b0;
    end else begin
        if (!cs_low)
            rd_q <= 1'b0;
        else if (rd_start)
            rd_q <= 1'b1;
        if (byte_done && (rd_q || rd_start))
            osh_q <= status;
        else if (sclk_dn && rd_q)
            osh_q <= {osh_q[6:0], 1'b0};
        if (hw_show)
            so_q <= ~busy_q;
        else if (sclk_dn && rd_q)
            so_q <= osh_q[7];
        so_oe_q <= cs_low & (rd_q | hw_show);
    end
end

////////////////////////////////////////////////////////////////////////
// latches, word mode and self-timed operation

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        wen_q      <= 1'b0;
        inc_q      <= 1'b0;
        inc_last_q <= 1'b0;
        ptr_q      <= {`ADDR_BITS{1'b0}};
        hwb_q      <= 1'b0;
        busy_q     <= 1'b0;
        tmr_q      <= 32'h0;
        push_v_q   <= 1'b0;
        push_q     <= {`ENTRY_BITS{1'b0}};
    end else begin
        if (push_v_q && push_rdy)
            push_v_q <= 1'b0;
        if (tmr_q != 32'h0)
            tmr_q <= tmr_q - 32'h1;
        if (busy_q && !push_v_q && tmr_q == 32'h0) begin
            busy_q <= 1'b0;
            if (!inc_q || inc_last_q) begin
                wen_q      <= 1'b0;
                inc_q      <= 1'b0;
                inc_last_q <= 1'b0;
            end
        end
        if (go) begin
            busy_q   <= 1'b1;
            tmr_q    <= go_cyc;
            push_v_q <= 1'b1;
            push_q   <= {go_kind, go_adr, go_dat};
            ptr_q    <= go_adr + `ADDR_STEP;
            inc_last_q <= (go_kind == `KIND_WORD_PROG) &&
                          ((go_adr | `MASK_WORD) >= unprot_top);
            if (go_inc)
                inc_q <= 1'b1;
        end
        if (one_op) begin
            case (opc_q)
                `OPC_WRITE_DISABLE: begin
                    wen_q      <= 1'b0;
                    inc_q      <= 1'b0;
                    inc_last_q <= 1'b0;
                end
                `OPC_WRITE_ENABLE: begin
                    if (!inc_q)
                        wen_q <= 1'b1;
                end
                `OPC_HW_BUSY_ON: begin
                    if (!inc_q)
                        hwb_q <= 1'b1;
                end
                `OPC_HW_BUSY_OFF: begin
                    if (!inc_q)
                        hwb_q <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end
end
// other opcodes in word mode, except write disable, fall through the cases above

////////////////////////////////////////////////////////////////////////
// operation buffer toward the array

wire [`ENTRY_BITS-1:0] head;

op_skid_buffer #(
    .W (`ENTRY_BITS)
) u_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (push_v_q),
    .in_ready  (push_rdy),
    .in_data   (push_q),
    .out_valid (op_valid),
    .out_ready (op_ready),
    .out_data  (head)
);

assign op_kind                = head[42:40];
assign op_addr                = head[39:16];
assign op_data                = head[15:0];
assign so_out                 = so_q;
assign so_oe                  = so_oe_q;
assign busy                   = busy_q;
assign write_enable_latch     = wen_q;
assign auto_increment_program = inc_q;
assign hw_busy_en             = hwb_q;

endmodule

// ---- tb/seq_monitor.sv ----
// port checks for the program/erase sequencer
// assumes the sequencer ports; attached by the bind at the foot
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module seq_monitor #(
    parameter [31:0] BP_CYC = 32'd2000,
    parameter [31:0] SE_CYC = 32'd5000000,
    parameter [31:0] BE_CYC = 32'd5000000,
    parameter [31:0] CE_CYC = 32'd10000000
) (
    input wire                  clk_sys,
    input wire                  arst_n,
    input wire                  cs_n_pin,
    input wire                  so_out,
    input wire                  so_oe,
    input wire [`ADDR_BITS-1:0] unprot_top,
    input wire                  op_valid,
    input wire                  op_ready,
    input wire [2:0]            op_kind,
    input wire [`ADDR_BITS-1:0] op_addr,
    input wire [15:0]           op_data,
    input wire                  busy,
    input wire                  write_enable_latch,
    input wire                  auto_increment_program,
    input wire                  hw_busy_en
);
    default clocking dck @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////
    chk_op_hold: assert property (op_valid && !op_ready |=>
        op_valid && $stable({op_kind, op_addr, op_data}))
        else $error("op fields moved while waiting");
    chk_start_cs: assert property ($rose(busy) |->
        $past(cs_n_pin, 2)) else $error("busy without cs release");
    chk_busy_len: assert property ($rose(busy) |-> busy[*8])
        else $error("busy too short");
    chk_need_latch: assert property ($rose(busy) |->
        $past(write_enable_latch)) else $error("write without latch");
    chk_latch_clr: assert property ($fell(busy) &&
        !auto_increment_program |-> !write_enable_latch)
        else $error("latch kept after op");
    chk_so_release: assert property (cs_n_pin[*4] |=> !so_oe)
        else $error("so driven while deselected");
    chk_hw_busy: assert property (so_oe && $past(so_oe) &&
        hw_busy_en && auto_increment_program && $past(busy) |-> !so_out)
        else $error("ready shown while busy");
    chk_word_mode: assert property (op_valid &&
        auto_increment_program |-> op_kind == 3'h2)
        else $error("foreign op in word mode");
    chk_word_even: assert property (op_valid && op_kind == 3'h2 |->
        !op_addr[0] && op_addr < unprot_top)
        else $error("word op odd or protected");
    chk_byte_prot: assert property (op_valid && op_kind == 3'h1 |->
        op_addr <= unprot_top) else $error("byte op protected");
    chk_sect_align: assert property (op_valid && op_kind == 3'h3 |->
        op_addr[11:0] == 12'h000 && op_data == 16'hffff)
        else $error("sector op misaligned");
    chk_blk_align: assert property (op_valid && op_kind[2] |->
        op_addr[14:0] == 15'h0000 && (op_kind != 3'h5 || !op_addr[15]))
        else $error("block op misaligned");
    chk_chip_prot: assert property (op_valid && op_kind == 3'h6 |->
        &unprot_top) else $error("chip op with protection");
    cov_byte: cover property (op_valid && op_kind == 3'h1);
    cov_word: cover property (op_valid && op_kind == 3'h2);
    cov_erase: cover property (op_valid && op_kind == 3'h6);
    cov_hw: cover property (so_oe && hw_busy_en && busy);
endmodule
bind spi_flash_program_erase_sequencer seq_monitor #(.BP_CYC(BP_CYC),
    .SE_CYC(SE_CYC), .BE_CYC(BE_CYC), .CE_CYC(CE_CYC)) mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .cs_n_pin(cs_n_pin),
    .so_out(so_out), .so_oe(so_oe), .unprot_top(unprot_top),
    .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
    .op_addr(op_addr), .op_data(op_data), .busy(busy),
    .write_enable_latch(write_enable_latch),
    .auto_increment_program(auto_increment_program),
    .hw_busy_en(hw_busy_en));

// ---- tb/spi_host.sv ----
// behavioural spi host, mode 0, 80 ns link clock
// assumes the device samples si on sclk rise; sclk still outside frames
`timescale 1ns/1ps
module spi_host (
    output reg  cs_n,
    output reg  sclk,
    output reg  si,
    input  wire so_out,
    input  wire so_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // undriven so reads as the inverse of the last bit taken
    task automatic frame(input [63:0] d, input integer nb,
                         output [15:0] rd);
        integer i;
        begin
            rd = 16'h0000;
            cs_n = 1'b0;
            #40;
            for (i = 8*nb-1; i >= 0; i = i-1) begin
                si = d[i];
                #40;
                sclk = 1'b1;
                rd = {rd[14:0], so_oe ? so_out : ~rd[0]};
                #40;
                sclk = 1'b0;
            end
            #40;
            cs_n = 1'b1;
            si = ~si;
            #100;
        end
    endtask
    task automatic peek(output [1:0] r);
        begin
            cs_n = 1'b0;
            #40;
            r = {so_oe, so_out};
            cs_n = 1'b1;
            #100;
        end
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the program/erase sequencer
// assumes spi_host and seq_monitor are compiled before it
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module tb;
    localparam [39:0]  EOP = 40'h2052d860c7;
    localparam [14:0]  EK  = {3'h3, 3'h4, 3'h5, 3'h6, 3'h6};
    localparam [119:0] EA  = {24'h0ab000, 24'h0a8000, 24'h0a0000, 48'h0};
    reg         clk_sys, arst_n, op_ready;
    reg  [23:0] unprot_top;
    wire        cs_n, sclk, si, so_out, so_oe, op_valid, busy, wen, inc, hwb;
    wire [2:0]  op_kind;
    wire [23:0] op_addr;
    wire [15:0] op_data;
    integer     error_cnt, cmp_count, i, n;
    reg  [15:0] rd;
    reg  [1:0]  pk;
    spi_host host (.cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out),
        .so_oe(so_oe));
    spi_flash_program_erase_sequencer #(.BP_CYC(32'd600), .SE_CYC(32'd40),
        .BE_CYC(32'd40), .CE_CYC(32'd60)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .cs_n_pin(cs_n),
        .sclk_pin(sclk), .si_pin(si), .so_out(so_out), .so_oe(so_oe),
        .unprot_top(unprot_top), .op_valid(op_valid), .op_ready(op_ready),
        .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
        .busy(busy), .write_enable_latch(wen),
        .auto_increment_program(inc), .hw_busy_en(hwb));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input [23:0] e, input [23:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task wait_idle;
        begin
            for (n = 0; n < 20000 && busy !== 1'b0; n = n+1)
                @(negedge clk_sys);
            chk("busy", 0, busy);
        end
    endtask
    // the backend stalls three cycles before taking the op
    task take_op(input [2:0] k, input [23:0] a, input [15:0] d);
        begin
            for (n = 0; n < 2000 && op_valid !== 1'b1; n = n+1)
                @(negedge clk_sys);
            repeat (3) @(negedge clk_sys);
            chk("op_valid", 1, op_valid);
            chk("op_kind", k, op_kind);
            chk("op_addr", a, op_addr);
            chk("op_data", d, op_data);
            op_ready = 1'b1;
            @(negedge clk_sys);
            op_ready = 1'b0;
        end
    endtask
    task no_op;
        begin
            repeat (40) @(negedge clk_sys);
            chk("idle busy", 0, busy);
            chk("idle op", 0, op_valid);
        end
    endtask
    task status(input [7:0] e);
        begin
            host.frame({8'h05, 16'h0}, 3, rd);
            chk("status", {e, e}, rd);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        close_out;
    end
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        op_ready = 1'b0;
        unprot_top = 24'hffffff;
        arst_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        status(8'h00);
        host.frame(8'h06, 1, rd);
        status(8'h02);
        host.frame({8'h02, 24'h001234, 8'ha5}, 5, rd);
        status(8'h03);
        take_op(3'h1, 24'h001234, 16'ha5ff);
        wait_idle;
        chk("latch", 0, wen);
        host.frame({8'h02, 24'h001234, 8'h5a}, 5, rd);
        no_op;
        host.frame(8'h06, 1, rd);
        host.frame({8'h02, 24'h001234}, 4, rd);
        no_op;
        unprot_top = 24'h0fffff;
        host.frame({8'h02, 24'h100000, 8'h00}, 5, rd);
        no_op;
        host.frame(8'hc7, 1, rd);
        no_op;
        unprot_top = 24'hffffff;
        for (i = 0; i < 5; i = i+1) begin
            host.frame(8'h06, 1, rd);
            if (i < 3)
                host.frame({EOP[39-8*i -: 8], 24'h0abcde}, 4, rd);
            else
                host.frame(EOP[39-8*i -: 8], 1, rd);
            take_op(EK[14-3*i -: 3], EA[119-24*i -: 24], 16'hffff);
            wait_idle;
        end
        host.frame(8'h06, 1, rd);
        host.frame({8'had, 24'h000101, 8'h11, 8'h22}, 6, rd);
        take_op(3'h2, 24'h000100, 16'h1122);
        wait_idle;
        chk("word mode", 1, inc);
        host.frame({8'h02, 24'h000200, 8'h00}, 5, rd);
        no_op;
        host.frame({8'had, 8'h33, 8'h44}, 3, rd);
        take_op(3'h2, 24'h000102, 16'h3344);
        wait_idle;
        host.frame(8'h04, 1, rd);
        chk("word mode off", 0, inc);
        chk("latch off", 0, wen);
        host.frame(8'h70, 1, rd);
        chk("hw busy on", 1, hwb);
        @(negedge clk_sys);
        unprot_top = 24'h0fffff;
        host.frame(8'h06, 1, rd);
        host.frame({8'had, 24'h0ffffc, 8'h55, 8'h66}, 6, rd);
        take_op(3'h2, 24'h0ffffc, 16'h5566);
        host.peek(pk);
        chk("so busy", 2'b10, pk);
        wait_idle;
        host.peek(pk);
        chk("so ready", 2'b11, pk);
        host.frame({8'had, 8'h77, 8'h88}, 3, rd);
        take_op(3'h2, 24'h0ffffe, 16'h7788);
        wait_idle;
        chk("top word mode", 0, inc);
        chk("top latch", 0, wen);
        host.frame(8'h80, 1, rd);
        chk("hw busy off", 0, hwb);
        close_out;
    end
endmodule
